/* design/fps_top.sv */
// fast pulse step counter with step monitor and apb registers
//
// Summary of operation
// [RL1] monitor sits at sequencer address 901..932
// [RL2] group 38..69 selects observed sequencer
// [RL3] special group needs mask programmed all ones
// [RL4] monitor data is decimal step number
// [RL5] timed or event choice changes nothing
// [RL6] greater-than bit sticks until monitor reset
// [RL7] reset can jump to a later step
// [RL8] chain position gives address 901..904
// [RL9] counting needs rate test and enable
// [RL10] pulses raise tally, target advances step
// [RL11] far side keeps pulse rate within limits
// [RL12] over-rate stops counting, freezes step, outputs
// [RL13] completion bit true for one scan
// [RL14] normal reset holds step 0 outputs
// [RL15] single shot keeps pulses for destination
// [RL16] shot code is 99 then step
// [RL17] eight pattern bits, six external
// [RL18] resident outputs immediate, expansion at scan
// [RL19] over-long scan faults with code 9; the code sets FAULT_O and a status bit, no code 9 is given
// [RL20] synchronise pulse, count each edge once
module fps_top
  import fps_pkg::*;
#(
  parameter int WIN_CYC  = fps_pkg::RATE_WIN_CYC,
  parameter int SCAN_CYC = fps_pkg::SCAN_MAX_CYC
)
(
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        PULSE_I,
  output logic      [5:0]  EXT_OUT_O,
  output logic             ENABLE_TEST_O,
  output logic             CYCLE_DONE_O,
  output logic             MONITOR_O,
  output logic             FAULT_O
);
  import fps_pkg::*;

  // ================
  // helpers
  // two bcd digits to binary
  function automatic logic [6:0] bcd2bin(input logic [7:0] bcd);
    logic [6:0] tens;
    tens = {3'b000, bcd[7:4]};
    bcd2bin = 7'((tens << 3) + (tens << 1) + {3'b000, bcd[3:0]});
  endfunction

  // pulse limit per window by module count
  function automatic logic [3:0] rate_limit(input logic [1:0] mcnt);
    case (mcnt)
      2'd0:    rate_limit = RATE_1MOD;
      2'd1:    rate_limit = RATE_2MOD;
      2'd2:    rate_limit = RATE_3MOD;
      default: rate_limit = RATE_4MOD;
    endcase
  endfunction

  // ================
  // declarations
  logic        ctrl_en_ff;     // counting enable from software
  logic        norm_rst_ff;    // normal reset level
  logic [1:0]  mod_cnt_ff;     // modules in chain minus one
  logic [1:0]  mod_pos_ff;     // position from processor
  logic [15:0] rst_code_ff;    // reset target code
  logic [3:0]  last_step_ff;   // final step number
  logic [5:0]  out_sel_ff;     // 1 = resident output
  logic [7:0]  mon_group_ff;   // monitor group number
  logic [7:0]  mon_mask_ff;    // monitor mask
  logic [7:0]  mon_data_ff;    // monitor step, bcd
  logic        mon_gt_ff;      // greater-than mode
  logic        mon_timed_ff;   // timed choice, kept only
  logic [4:0]  mon_addr_ff;    // monitor address minus 901
  logic [3:0]  tbl_idx_ff;     // table write index
  logic [3:0]  step_ff;        // current step
  logic [15:0] tally_ff;       // running tally
  logic [3:0]  nxt_step;
  logic [15:0] nxt_tally;
  logic        done_evt;       // last step completed
  logic        cyc_pend_ff;    // completion awaiting scan
  logic        cyc_vis_ff;     // completion shown this scan
  logic        mon_hit_ff;     // monitor status bit
  logic [5:0]  ext_out_ff;     // external outputs
  logic [31:0] scan_cnt_ff;    // cycles in this scan
  logic        fault_ff;       // scan too long
  logic        en_test_ff;     // enable test output
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [23:0] step_word;      // table word for step_ff
  logic        pulse_edge;
  logic        over_rate;
  logic        setup_ph;
  logic        wr_acc;
  logic        mapped;
  logic        shot_req;
  logic        mon_rst_req;
  logic        scan_mark;
  logic        tbl_we;
  logic        count_en;
  logic [3:0]  shot_step;
  logic [6:0]  shot_bin;       // shot destination, binary
  logic [6:0]  mon_step;
  logic        mon_valid;
  logic [9:0]  my_addr;

  // ================
  // apb decode
  assign setup_ph    = PSEL_I & ~PENABLE_I;
  assign wr_acc      = PSEL_I & PENABLE_I & pready_ff & PWRITE_I & ~pslverr_ff;
  assign shot_req    = wr_acc && PADDR_I == OFS_SHOT;
  assign mon_rst_req = wr_acc && PADDR_I == OFS_MON_CTRL;
  assign scan_mark   = wr_acc && PADDR_I == OFS_SCAN;
  assign tbl_we      = wr_acc && PADDR_I == OFS_TBL_DATA;

  // known offsets
  always_comb
  begin
    case (PADDR_I)
      OFS_CTRL, OFS_RST_CODE, OFS_SHOT, OFS_STATUS, OFS_POSITION,
      OFS_MON_CFG, OFS_MON_CTRL, OFS_SCAN, OFS_TBL_IDX, OFS_TBL_DATA,
      OFS_SEQ_CFG: mapped = 1'b1;
      default:     mapped = 1'b0;
    endcase
  end

  // ready, error and read data set up one cycle ahead
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~mapped;
      // unmapped access of either kind reads zero
      if (setup_ph && (!PWRITE_I || !mapped))
      begin
        case (PADDR_I)
          OFS_CTRL:     prdata_ff <= {24'h000000, mod_pos_ff, mod_cnt_ff, 2'b00, norm_rst_ff, ctrl_en_ff};
          OFS_RST_CODE: prdata_ff <= {16'h0000, rst_code_ff};
          OFS_STATUS:   prdata_ff <= {17'h00000, my_addr, fault_ff, mon_hit_ff, cyc_vis_ff,
                                      over_rate, en_test_ff};
          OFS_POSITION: prdata_ff <= {8'h00, step_word[23:16], tally_ff} | {4'h0, step_ff, 24'h000000};
          OFS_MON_CFG:  prdata_ff <= {1'b0, mon_addr_ff, mon_timed_ff, mon_gt_ff, mon_data_ff,
                                      mon_mask_ff, mon_group_ff};
          OFS_TBL_IDX:  prdata_ff <= {28'h0000000, tbl_idx_ff};
          OFS_SEQ_CFG:  prdata_ff <= {16'h0000, 2'b00, out_sel_ff, 4'h0, last_step_ff};
          default:      prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // ================
  // control registers
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl_en_ff   <= 1'b0;
      norm_rst_ff  <= 1'b0;
      mod_cnt_ff   <= 2'b00;
      mod_pos_ff   <= 2'b00;
      rst_code_ff  <= RST_CODE_RST;
      last_step_ff <= LAST_STEP_RST;
      out_sel_ff   <= OUT_SEL_RST;
      tbl_idx_ff   <= 4'h0;
    end
    else if (wr_acc)
    begin
      case (PADDR_I)
        OFS_CTRL:
        begin
          ctrl_en_ff  <= PWDATA_I[CTRL_EN_BIT];
          norm_rst_ff <= PWDATA_I[CTRL_NRST_BIT];
          mod_cnt_ff  <= PWDATA_I[CTRL_MCNT_LSB +: 2];
          mod_pos_ff  <= PWDATA_I[CTRL_MPOS_LSB +: 2];
        end
        OFS_RST_CODE: rst_code_ff  <= PWDATA_I[15:0];
        OFS_TBL_IDX:  tbl_idx_ff   <= PWDATA_I[3:0];
        OFS_SEQ_CFG:
        begin
          last_step_ff <= PWDATA_I[3:0];
          out_sel_ff   <= PWDATA_I[SEQ_SEL_LSB +: EXT_BITS];
        end
        default: ;
      endcase
    end
  end

  // monitor setup register
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      mon_group_ff <= 8'h00;
      mon_mask_ff  <= 8'h00;
      mon_data_ff  <= 8'h00;
      mon_gt_ff    <= 1'b0;
      mon_timed_ff <= 1'b0;
      mon_addr_ff  <= 5'h00;
    end
    else if (wr_acc && PADDR_I == OFS_MON_CFG)
    begin
      mon_group_ff <= PWDATA_I[7:0];
      mon_mask_ff  <= PWDATA_I[MON_MASK_LSB +: 8];
      mon_data_ff  <= PWDATA_I[MON_DATA_LSB +: 8];
      mon_gt_ff    <= PWDATA_I[MON_GT_BIT];
      // [RL5] stored for readback, never used
      mon_timed_ff <= PWDATA_I[MON_TIMED_BIT];
      // [RL1] five bits keep address within 901..932
      mon_addr_ff  <= PWDATA_I[MON_ADDR_LSB +: 5];
    end
  end

  // ================
  // pulse input and step table
  fps_pulse_in #(.WIN_CYC(WIN_CYC)) u_pulse
  (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pulse_i (PULSE_I),
    .limit_i (rate_limit(mod_cnt_ff)),
    .clr_i   (norm_rst_ff | shot_req),
    .edge_o  (pulse_edge),
    .over_o  (over_rate)
  );

  // [RL17] eight pattern bits per step
  fps_step_mem u_mem
  (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .we_i    (tbl_we),
    .waddr_i (tbl_idx_ff),
    .wdata_i (PWDATA_I[23:0]),
    .raddr_i (nxt_step),
    .rdata_o (step_word)
  );

  // ================
  // step engine
  // [RL8] chain position fixes this counter's address
  assign my_addr  = SEQ_ADDR_FIRST + {8'h00, mod_pos_ff};
  // [RL9] rate test and software enable gate counting
  assign count_en = ctrl_en_ff & ~over_rate & ~norm_rst_ff;
  // [RL16] 99 prefix, then bcd destination step
  assign shot_bin  = bcd2bin(rst_code_ff[7:0]);
  assign shot_step = (rst_code_ff[15:8] == SHOT_PREFIX && shot_bin <= {3'b000, last_step_ff})
                     ? shot_bin[3:0] : 4'h0;

  // next step and tally
  always_comb
  begin
    nxt_step  = step_ff;
    nxt_tally = tally_ff;
    done_evt  = 1'b0;
    // [RL14] normal reset holds step 0
    if (norm_rst_ff)
    begin
      nxt_step  = 4'h0;
      nxt_tally = 16'h0000;
    end
    // [RL7] [RL15] jump, keeping this cycle's pulse
    else if (shot_req)
    begin
      nxt_step  = shot_step;
      nxt_tally = (pulse_edge && ctrl_en_ff) ? 16'h0001 : 16'h0000;
    end
    // [RL10] count, advance at target
    else if (count_en && pulse_edge)
    begin
      if (tally_ff + 16'h0001 >= step_word[15:0])
      begin
        nxt_tally = 16'h0000;
        if (step_ff == last_step_ff)
        begin
          nxt_step = 4'h0;
          done_evt = 1'b1;
        end
        else
        begin
          nxt_step = step_ff + 4'h1;
        end
      end
      else
      begin
        nxt_tally = tally_ff + 16'h0001;
      end
    end
  end

  // [RL12] over-rate blocks counting; shot and normal reset still update
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      step_ff  <= 4'h0;
      tally_ff <= 16'h0000;
    end
    else
    begin
      step_ff  <= nxt_step;
      tally_ff <= nxt_tally;
    end
  end

  // [RL13] completion shown for one scan, set wins
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cyc_pend_ff <= 1'b0;
      cyc_vis_ff  <= 1'b0;
    end
    else
    begin
      if (scan_mark)
      begin
        cyc_vis_ff  <= cyc_pend_ff;
        cyc_pend_ff <= done_evt;
      end
      else if (done_evt)
      begin
        cyc_pend_ff <= 1'b1;
      end
    end
  end

  // enable test reads false while over-rate
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      en_test_ff <= 1'b0;
    end
    else
    begin
      en_test_ff <= ~over_rate;
    end
  end

  // ================
  // outputs
  // [RL18] resident bits follow step, others wait for scan
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ext_out_ff <= 6'h00;
    end
    else
    begin
      for (int i = 0; i < EXT_BITS; i++)
      begin
        if (out_sel_ff[i] || scan_mark)
        begin
          ext_out_ff[i] <= step_word[TBL_OUT_LSB + i];
        end
      end
    end
  end

  // ================
  // step monitor
  // [RL2] [RL3] group must match this address, mask all ones
  assign mon_valid = mon_mask_ff == MASK_ALL && mon_group_ff >= GROUP_FIRST && mon_group_ff <= GROUP_LAST
                     && (mon_group_ff - GROUP_FIRST) == {6'h00, mod_pos_ff};
  // [RL4] decimal step number
  assign mon_step  = bcd2bin(mon_data_ff);

  // [RL6] greater-than bit sticks, set wins over reset
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      mon_hit_ff <= 1'b0;
    end
    else if (!mon_valid)
    begin
      mon_hit_ff <= 1'b0;
    end
    else if (mon_gt_ff)
    begin
      if ({3'b000, step_ff} > mon_step)
      begin
        mon_hit_ff <= 1'b1;
      end
      else if (mon_rst_req)
      begin
        mon_hit_ff <= 1'b0;
      end
    end
    else
    begin
      mon_hit_ff <= {3'b000, step_ff} == mon_step;
    end
  end

  // ================
  // scan watchdog
  // [RL19] fault when no scan mark within limit
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || scan_mark)
    begin
      scan_cnt_ff <= 32'h00000000;
    end
    else if (scan_cnt_ff != 32'(SCAN_CYC))
    begin
      scan_cnt_ff <= scan_cnt_ff + 32'h00000001;
    end
  end

  // fault latch, cleared only by system reset
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      fault_ff <= 1'b0;
    end
    else if (scan_cnt_ff == 32'(SCAN_CYC))
    begin
      fault_ff <= 1'b1;
    end
  end

  assign PRDATA_O      = prdata_ff;
  assign PREADY_O      = pready_ff;
  assign PSLVERR_O     = pslverr_ff;
  assign EXT_OUT_O     = ext_out_ff;
  assign ENABLE_TEST_O = en_test_ff;
  assign CYCLE_DONE_O  = cyc_vis_ff;
  assign MONITOR_O     = mon_hit_ff;
  assign FAULT_O       = fault_ff;
endmodule

/* design/fps_pkg.sv */
// constants shared by the fast pulse step counter design
package fps_pkg;
  // ================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL      = 8'h00; // enable, normal reset, chain setup
  localparam logic [7:0] OFS_RST_CODE  = 8'h04; // reset target code
  localparam logic [7:0] OFS_SHOT      = 8'h08; // single shot reset strobe
  localparam logic [7:0] OFS_STATUS    = 8'h0c; // counter status
  localparam logic [7:0] OFS_POSITION  = 8'h10; // step and running tally
  localparam logic [7:0] OFS_MON_CFG   = 8'h14; // monitor setup
  localparam logic [7:0] OFS_MON_CTRL  = 8'h18; // monitor reset strobe
  localparam logic [7:0] OFS_SCAN      = 8'h1c; // end of program scan strobe
  localparam logic [7:0] OFS_TBL_IDX   = 8'h20; // step table index
  localparam logic [7:0] OFS_TBL_DATA  = 8'h24; // step table data
  localparam logic [7:0] OFS_SEQ_CFG   = 8'h28; // last step, output routing
  // ================
  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_NRST_BIT  = 1;
  localparam int CTRL_MCNT_LSB  = 4;
  localparam int CTRL_MPOS_LSB  = 6;
  localparam int MON_MASK_LSB   = 8;
  localparam int MON_DATA_LSB   = 16;
  localparam int MON_GT_BIT     = 24;
  localparam int MON_TIMED_BIT  = 25;
  localparam int MON_ADDR_LSB   = 26;
  localparam int TBL_OUT_LSB    = 16;
  localparam int SEQ_SEL_LSB    = 8;
  // ================
  // reset values
  localparam logic [15:0] RST_CODE_RST = 16'h0000;
  localparam logic [3:0]  LAST_STEP_RST = 4'h0;
  localparam logic [5:0]  OUT_SEL_RST   = 6'h3f;
  // ================
  // addressing, group numbers and codes
  localparam logic [9:0] SEQ_ADDR_FIRST = 10'd901;
  localparam logic [9:0] SEQ_ADDR_LAST  = 10'd932;
  localparam logic [9:0] MOD_ADDR_LAST  = 10'd904;
  localparam logic [9:0] STATUS_OFFSET  = 10'd50;
  localparam logic [7:0] GROUP_FIRST    = 8'd38;
  localparam logic [7:0] GROUP_LAST     = 8'd69;
  localparam logic [7:0] MASK_ALL       = 8'hff;
  localparam logic [7:0] SHOT_PREFIX    = 8'h99;
  localparam logic [3:0] FAULT_SCAN     = 4'h9;
  localparam int         OUT_BITS       = 8;
  localparam int         EXT_BITS       = 6;
  // ================
  // pulse rate limits, pulses per window, by module count
  localparam logic [3:0] RATE_1MOD = 4'd5;
  localparam logic [3:0] RATE_2MOD = 4'd4;
  localparam logic [3:0] RATE_3MOD = 4'd3;
  localparam logic [3:0] RATE_4MOD = 4'd2;
  localparam logic [3:0] RATE_SUM  = 4'd5;
  // ================
  // timing
  localparam int CLK_MHZ       = 125;
  localparam int RATE_WIN_US   = 1000;
  localparam int RATE_WIN_CYC  = RATE_WIN_US * CLK_MHZ;
  localparam int SCAN_MAX_MS   = 100;
  localparam int SCAN_MAX_CYC  = SCAN_MAX_MS * 1000 * CLK_MHZ;
endpackage

/* design/fps_step_mem.sv */
// step table memory: target tally and output pattern per step
module fps_step_mem
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [23:0] wdata_i,
  input  wire logic [3:0]  raddr_i,
  output logic      [23:0] rdata_o
);
  // ================
  // storage
  logic [23:0] mem_ff [16]; // one word per step

  // write port
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 24'h000000;
    end
    else
    begin
      rdata_o <= mem_ff[raddr_i];
    end
  end
endmodule

/* design/fps_pulse_in.sv */
// pulse input: synchroniser, rising edge detect, over-rate watch
module fps_pulse_in
#(
  parameter int WIN_CYC = 125000
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pulse_i,
  input  wire logic [3:0] limit_i,
  input  wire logic       clr_i,
  output logic            edge_o,
  output logic            over_o
);
  // ================
  // state
  logic        sync1_ff;   // first stage, read only by sync2
  logic        sync2_ff;   // settled level
  logic        prev_ff;    // level one cycle ago
  logic [31:0] win_ff;     // window cycle count
  logic [3:0]  cnt_ff;     // pulses in this window
  logic        over_ff;    // over-rate latch

  assign edge_o = sync2_ff & ~prev_ff;
  assign over_o = over_ff;

  // [RL20] two-stage synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end
    else
    begin
      sync1_ff <= pulse_i;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // rate window and pulse count
  always_ff @(posedge clk_i)
  begin
    if (rst_i || win_ff == 32'(WIN_CYC - 1))
    begin
      win_ff <= 32'h00000000;
      cnt_ff <= 4'h0;
    end
    else
    begin
      win_ff <= win_ff + 32'h00000001;
      if (edge_o && cnt_ff != 4'hf)
      begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // [RL12] latch over-rate, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      over_ff <= 1'b0;
    end
    else if (edge_o && cnt_ff >= limit_i)
    begin
      over_ff <= 1'b1;
    end
    else if (clr_i)
    begin
      over_ff <= 1'b0;
    end
  end
endmodule

/* test/fps_pulse_src.sv */
// field pulse source model: a sensor that emits bursts of clean pulses
module fps_pulse_src
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] num_i,
  input  wire logic [7:0] half_i,
  output logic            pulse_o = 1'h0,
  output logic            busy_o = 1'h0
);
  // ================
  // burst: half_i clocks high, half_i low
  always @(posedge clk_i)
  begin
    if (go_i && !busy_o)
    begin
      busy_o <= 1'h1;
      repeat (num_i)
      begin
        pulse_o <= 1'h1;
        repeat (half_i) @(posedge clk_i);
        pulse_o <= 1'h0;
        repeat (half_i) @(posedge clk_i);
      end
      busy_o <= 1'h0;
    end
  end
endmodule

/* test/fps_top_sva.sv */
// port checker for the fast pulse step counter
module fps_top_sva
  import fps_pkg::*;
#(
  parameter int SCAN_CYC = 500
)
(
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [5:0]  EXT_OUT_O,
  input wire logic        ENABLE_TEST_O,
  input wire logic        CYCLE_DONE_O,
  input wire logic        MONITOR_O,
  input wire logic        FAULT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire logic   wr_acc  = PSEL_I && PENABLE_I && PWRITE_I; // any write
  wire logic   scan_wr = wr_acc && PADDR_I == OFS_SCAN;   // scan mark
  int unsigned idle_ff; // cycles since scan mark
  // ================
  // idle cycles, saturating
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || scan_wr)
      idle_ff <= 0;
    else if (idle_ff < SCAN_CYC + 8)
      idle_ff <= idle_ff + 1;
  end
  a_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready");
  a_ready_access: assert property (PREADY_O |-> PENABLE_I && $past(PSEL_I && !PENABLE_I)) else $error("stray ready");
  a_ready_single: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  a_err_zero: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0) else $error("bad refusal");
  a_reset_clear: assert property (disable iff (1'h0) SYS_RST_I |=> !PREADY_O && EXT_OUT_O == 6'h0 && !FAULT_O)
    else $error("reset left outputs");
  a_done_on_scan: assert property ($changed(CYCLE_DONE_O) |-> $past(scan_wr) || $past(SYS_RST_I))
    else $error("done off scan");
  a_freeze_out: assert property ((!ENABLE_TEST_O && !wr_acc) [*4] |-> $stable(EXT_OUT_O))
    else $error("outputs moved");
  a_fault_sticky: assert property (FAULT_O |=> FAULT_O) else $error("fault dropped");
  a_fault_early: assert property ($rose(FAULT_O) |-> idle_ff + 4 >= SCAN_CYC) else $error("fault early");
  a_fault_late: assert property (idle_ff == SCAN_CYC + 4 |-> FAULT_O) else $error("fault late");
  c_done: cover property ($rose(CYCLE_DONE_O));
  c_over: cover property ($fell(ENABLE_TEST_O));
  c_mon: cover property ($rose(MONITOR_O));
  c_fault: cover property ($rose(FAULT_O));
endmodule
bind fps_top fps_top_sva #(.SCAN_CYC(SCAN_CYC)) fps_top_sva_i
(
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .EXT_OUT_O(EXT_OUT_O), .ENABLE_TEST_O(ENABLE_TEST_O),
  .CYCLE_DONE_O(CYCLE_DONE_O), .MONITOR_O(MONITOR_O), .FAULT_O(FAULT_O)
);

/* test/fps_top_test.sv */
// self-checking bench for the fast pulse step counter
module fps_top_test
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCAN = 500; // shortened watchdog
  logic        CLK_I = 1'h0, SYS_RST_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0;
  logic [7:0]  PADDR_I = 8'h0, num = 8'h0, half = 8'h2, pat [4];
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdat, frozen;
  logic        PREADY_O, PSLVERR_O, PULSE_I, ENABLE_TEST_O, CYCLE_DONE_O, MONITOR_O, FAULT_O, err, busy;
  logic        go = 1'h0, done = 1'h0;
  logic [5:0]  EXT_OUT_O;
  logic [15:0] tgt [4], tally = 16'h0;
  logic [15:0] codes [4] = '{16'h9902, 16'h9909, 16'h1203, 16'h9903};
  logic [3:0]  step = 4'h0, last = 4'h3;
  int          failures = 0, checks_done = 0, seed = 89098;
  always #4 CLK_I = ~CLK_I;
  fps_top #(.WIN_CYC(200), .SCAN_CYC(SCAN)) fps_top_i
  (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .PULSE_I(PULSE_I), .EXT_OUT_O(EXT_OUT_O), .ENABLE_TEST_O(ENABLE_TEST_O),
    .CYCLE_DONE_O(CYCLE_DONE_O), .MONITOR_O(MONITOR_O), .FAULT_O(FAULT_O)
  );
  fps_pulse_src fps_pulse_src_i
  (
    .clk_i(CLK_I), .go_i(go), .num_i(num), .half_i(half), .pulse_o(PULSE_I), .busy_o(busy)
  );
  // ================
  // verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL_I <= 1'h1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    k = 0;
    do
    begin
      @(posedge CLK_I);
      k++;
    end
    while (PREADY_O !== 1'h1 && k < 16);
    if (k >= 16)
    begin
      failures++;
      final_report();
    end
    rdat = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
    @(posedge CLK_I);
  endtask
  // ================
  // step model: one counted pulse
  function automatic void adv();
    tally = tally + 16'h1;
    if (tally >= tgt[step])
    begin
      tally = 16'h0;
      done = done | (step == last);
      step = (step == last) ? 4'h0 : step + 4'h1;
    end
  endfunction
  function automatic logic [31:0] pos();
    return {4'h0, step, pat[step], tally};
  endfunction
  function automatic logic [3:0] sstep(input logic [15:0] c);
    int s;
    s = c[7:4] * 10 + c[3:0];
    return (c[15:8] == SHOT_PREFIX && s <= last) ? 4'(s) : 4'h0;
  endfunction
  // burst, scan mark, mode 1 counts, 2 holds
  task automatic ps(input int n, h, mode);
    int k;
    num <= 8'(n);
    half <= 8'(h);
    go <= 1'h1;
    @(posedge CLK_I);
    go <= 1'h0;
    k = 0;
    do
    begin
      @(posedge CLK_I);
      k++;
    end
    while (busy !== 1'h0 && k < 2000);
    if (k >= 2000)
    begin
      failures++;
      final_report();
    end
    repeat (8) @(posedge CLK_I);
    apb(1'h1, OFS_SCAN, 32'h0);
    if (mode == 1)
    begin
      repeat (n) adv();
      chk("done", 32'(done), 32'(CYCLE_DONE_O));
      chk("outputs", 32'(pat[step][5:0]), 32'(EXT_OUT_O));
    end
    done = 1'h0;
    apb(1'h0, OFS_POSITION, 32'h0);
    if (mode > 0)
      chk("position", pos(), rdat);
  endtask
  // monitor setup, shot, check
  task automatic mset(input logic [31:0] c, input logic [15:0] code, input logic e);
    apb(1'h1, OFS_MON_CFG, c);
    if (code !== 16'h0)
    begin
      apb(1'h1, OFS_RST_CODE, 32'(code));
      apb(1'h1, OFS_SHOT, 32'h0);
    end
    repeat (4) @(posedge CLK_I);
    chk("monitor", 32'(e), 32'(MONITOR_O));
  endtask
  // ================
  // main sequence
  initial
  begin
    repeat (20) @(posedge CLK_I);
    SYS_RST_I <= 1'h0;
    apb(1'h0, OFS_SEQ_CFG, 32'h0);
    chk("seq cfg", {18'h0, OUT_SEL_RST, 4'h0, LAST_STEP_RST}, rdat);
    for (int p = 0; p < 4; p++)
    begin
      apb(1'h1, OFS_CTRL, 32'(p) << 6);
      apb(1'h0, OFS_STATUS, 32'h0);
      chk("status", {17'h0, SEQ_ADDR_FIRST + 10'(p), 5'h01}, rdat);
    end
    apb(1'h1, 8'h40, 32'h0);
    chk("refused", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++)
    begin
      tgt[i] = (i == 1) ? 16'h0 : 16'(($random(seed) & 3) + 1);
      pat[i] = 8'($random(seed));
      apb(1'h1, OFS_TBL_IDX, 32'(i));
      apb(1'h1, OFS_TBL_DATA, {8'h0, pat[i], tgt[i]});
    end
    apb(1'h1, OFS_SEQ_CFG, {18'h0, OUT_SEL_RST, 4'h0, last});
    apb(1'h1, OFS_CTRL, 32'h0);
    ps(2, 25, 2);
    apb(1'h1, OFS_CTRL, 32'h1);
    repeat (6) ps(1 + ($random(seed) & 3), 25, 1);
    $display("test counting done");
    ps(14, 2, 0);
    frozen = rdat;
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("rate latch", 32'h2, 32'(rdat[1:0]));
    ps(2, 25, 0);
    chk("frozen", frozen, rdat);
    foreach (codes[i])
    begin
      apb(1'h1, OFS_RST_CODE, 32'(codes[i]));
      apb(1'h1, OFS_SHOT, 32'h0);
      step = sstep(codes[i]);
      tally = 16'h0;
      apb(1'h0, OFS_POSITION, 32'h0);
      chk("shot", pos(), rdat);
    end
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("rate clear", 32'h1, 32'(rdat[1:0]));
    ps(1, 25, 1);
    $display("test over rate done");
    apb(1'h1, OFS_CTRL, 32'h3);
    step = 4'h0;
    tally = 16'h0;
    ps(2, 25, 2);
    chk("reset outputs", 32'(pat[0][5:0]), 32'(EXT_OUT_O));
    apb(1'h1, OFS_CTRL, 32'h1);
    for (int t = 0; t < 2; t++)
    begin
      mset({6'h0, 1'(t), 1'h0, 8'h00, 8'hff, 8'h26}, 16'h9900, 1'h1);
      mset({6'h0, 1'(t), 1'h0, 8'h00, 8'hfe, 8'h26}, 16'h0, 1'h0);
      mset({6'h0, 1'(t), 1'h0, 8'h00, 8'hff, 8'h27}, 16'h0, 1'h0);
      mset({6'h0, 1'(t), 1'h1, 8'h02, 8'hff, 8'h26}, 16'h9903, 1'h1);
      mset({6'h0, 1'(t), 1'h1, 8'h02, 8'hff, 8'h26}, 16'h9900, 1'h1);
      apb(1'h1, OFS_MON_CTRL, 32'h0);
      repeat (4) @(posedge CLK_I);
      chk("monitor clear", 32'h0, 32'(MONITOR_O));
    end
    $display("test monitor done");
    repeat (SCAN + 20) @(posedge CLK_I);
    chk("fault", 32'h1, 32'(FAULT_O));
    $display("test watchdog done");
    final_report();
  end
endmodule
